// ==== msc_param_bank.sv ====
// Motor sensor polarity, fault history, phase order and current loop parameter bank
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Eight-bit polarity object; bit 0 flips encoder count, bit 1 Hall polarity.
// - Bit 2 inverts each Hall bit, bit 3 the electrical angle; 4-7 unused.
// - Hall pole-pair count, eight bits, 0 to 255, reset zero.
// - Fault count at subindex zero, 0 to 10, cleared at power-up.
// - Writing zero to the fault count clears the whole history.
// - New fault codes append in order to read-only subindices 1 to 10.
// - Phase order 0 to 5 routes the three PWM outputs onto motor phases.
// - Signed angle offset in tenths of a degree, -3600..3600, added to angle.
// - Live Hall pattern readable, U V W in bits 0 to 2, valid 1..6.
// - D-axis proportional gain at subindex 1, 0 to 100000000, reset 1000.
// - Q-axis proportional and integral gains at subindices 4 and 5, same range.
// - Current loop bandwidth in hertz, 1000 to 10000, reset 2000.
module msc_param_bank (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic od_req,
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  output logic od_ack,
  output logic od_abort,
  output logic [31:0] od_rdata,
  input wire logic fault_push,
  input wire logic [15:0] fault_code,
  input wire logic [31:0] enc_count_in,
  output logic [31:0] enc_count_out,
  input wire logic [2:0] hall_in,
  output logic [2:0] hall_out,
  output logic hall_valid,
  input wire logic [15:0] angle_in,
  output logic [15:0] angle_out,
  input wire logic [2:0] pwm_in,
  output logic [2:0] motor_uvw,
  output logic [7:0] pole_pairs,
  output logic [31:0] d_pgain,
  output logic [31:0] q_pgain,
  output logic [31:0] q_igain,
  output logic [15:0] cur_bw
);

  // ----------------------------------------------------------------
  // Object decode
  // ----------------------------------------------------------------
  logic [7:0] polarity_r;
  logic [7:0] pole_pairs_r;
  logic [15:0] phase_r;
  logic [15:0] angle_ofs_r;
  logic [31:0] d_pgain_r;
  logic [31:0] q_pgain_r;
  logic [31:0] q_igain_r;
  logic [15:0] cur_bw_r;
  logic [2:0] hall_r;
  logic [31:0] enc_r;
  logic [15:0] angle_r;
  logic [2:0] motor_r;
  logic hall_valid_r;
  logic ack_r;
  logic abort_r;
  logic [31:0] rdata_r;

  logic [15:0] log_rd;
  logic [3:0] log_count;

  wire sub0 = (od_sub == msc_pkg::SUB_ZERO);
  wire hit_pol = (od_index == msc_pkg::IDX_POLARITY) && sub0;
  wire hit_pp = (od_index == msc_pkg::IDX_POLE_PAIRS) && sub0;
  wire hit_cnt = (od_index == msc_pkg::IDX_FAULT_LOG) && sub0;
  wire hit_fent = (od_index == msc_pkg::IDX_FAULT_LOG) && (od_sub >= msc_pkg::SUB_FAULT_FIRST)
                  && (od_sub <= msc_pkg::SUB_FAULT_LAST);
  wire hit_phase = (od_index == msc_pkg::IDX_PHASE_ORDER) && sub0;
  wire hit_ang = (od_index == msc_pkg::IDX_ANGLE_OFS) && sub0;
  wire hit_hall = (od_index == msc_pkg::IDX_HALL_PAT) && sub0;
  wire hit_gn = (od_index == msc_pkg::IDX_CUR_GAINS) && sub0;
  wire hit_dp = (od_index == msc_pkg::IDX_CUR_GAINS) && (od_sub == msc_pkg::SUB_D_PGAIN);
  wire hit_qp = (od_index == msc_pkg::IDX_CUR_GAINS) && (od_sub == msc_pkg::SUB_Q_PGAIN);
  wire hit_qi = (od_index == msc_pkg::IDX_CUR_GAINS) && (od_sub == msc_pkg::SUB_Q_IGAIN);
  wire hit_bw = (od_index == msc_pkg::IDX_CUR_BW) && sub0;
  wire known = hit_pol | hit_pp | hit_cnt | hit_fent | hit_phase | hit_ang | hit_hall | hit_gn
               | hit_dp | hit_qp | hit_qi | hit_bw;

  // ----------------------------------------------------------------
  // Range checks
  // ----------------------------------------------------------------
  wire wr = od_req && od_wr;
  wire hi24_zero = (od_wdata[31:8] == 24'h000000);
  wire hi16_zero = (od_wdata[31:16] == 16'h0000);
  wire signed [15:0] ang_val = $signed(od_wdata[15:0]);
  wire gain_ok = (od_wdata <= msc_pkg::GAIN_MAX);
  wire ok_pol = hit_pol && hi24_zero;
  wire ok_pp = hit_pp && hi24_zero;
  wire ok_cnt = hit_cnt && (od_wdata == 32'h0000_0000);
  wire ok_phase = hit_phase && hi16_zero && (od_wdata[15:0] <= msc_pkg::PHASE_MAX);
  // Offset object is 16 bits wide; only the low half is taken as a signed value
  wire ok_ang = hit_ang && (ang_val >= msc_pkg::ANGLE_OFS_MIN) && (ang_val <= msc_pkg::ANGLE_OFS_MAX);
  wire ok_dp = hit_dp && gain_ok;
  wire ok_qp = hit_qp && gain_ok;
  wire ok_qi = hit_qi && gain_ok;
  wire ok_bw = hit_bw && hi16_zero && (od_wdata[15:0] >= msc_pkg::CUR_BW_MIN)
               && (od_wdata[15:0] <= msc_pkg::CUR_BW_MAX);
  wire any_ok = ok_pol | ok_pp | ok_cnt | ok_phase | ok_ang | ok_dp | ok_qp | ok_qi | ok_bw;
  // Read-only entries never reach any_ok, so writing them aborts
  wire abort_nxt = od_req && (!known || (od_wr && !any_ok));
  wire log_clear = wr && ok_cnt;

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  wire [31:0] rd_val =
    hit_pol ? {24'h000000, polarity_r} :
    hit_pp ? {24'h000000, pole_pairs_r} :
    hit_cnt ? {28'h0000000, log_count} :
    hit_fent ? {16'h0000, log_rd} :
    hit_phase ? {16'h0000, phase_r} :
    hit_ang ? {16'h0000, angle_ofs_r} :
    hit_hall ? {29'h00000000, hall_r} :
    hit_gn ? {24'h000000, msc_pkg::CUR_GAIN_ENTRIES} :
    hit_dp ? d_pgain_r :
    hit_qp ? q_pgain_r :
    hit_qi ? q_igain_r :
    hit_bw ? {16'h0000, cur_bw_r} : 32'h0000_0000;

  msc_fault_log u_fault_log (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .push(fault_push),
    .code(fault_code),
    .clear(log_clear),
    .rd_sel(od_sub[3:0]),
    .rd_data(log_rd),
    .count(log_count)
  );

  // ----------------------------------------------------------------
  // Stored objects
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      polarity_r <= msc_pkg::POLARITY_RST;
      pole_pairs_r <= msc_pkg::POLE_PAIRS_RST;
      phase_r <= msc_pkg::PHASE_RST;
      angle_ofs_r <= msc_pkg::ANGLE_OFS_RST;
    end else if (wr) begin
      // Reserved polarity bits are not stored and read as zero
      if (ok_pol) polarity_r <= od_wdata[7:0] & msc_pkg::POL_USED_MASK;
      if (ok_pp) pole_pairs_r <= od_wdata[7:0];
      if (ok_phase) phase_r <= od_wdata[15:0];
      if (ok_ang) angle_ofs_r <= od_wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      d_pgain_r <= msc_pkg::GAIN_RST;
      q_pgain_r <= msc_pkg::GAIN_RST;
      q_igain_r <= msc_pkg::GAIN_RST;
      cur_bw_r <= msc_pkg::CUR_BW_RST;
    end else if (wr) begin
      if (ok_dp) d_pgain_r <= od_wdata;
      if (ok_qp) q_pgain_r <= od_wdata;
      if (ok_qi) q_igain_r <= od_wdata;
      if (ok_bw) cur_bw_r <= od_wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      abort_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= od_req;
      abort_r <= abort_nxt;
      rdata_r <= (od_req && !od_wr && known) ? rd_val : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Sensor and commutation path
  // ----------------------------------------------------------------
  wire [2:0] hall_each = polarity_r[msc_pkg::POL_HALL_EACH_BIT] ? ~hall_in : hall_in;
  // Overall polarity reverses rotation sense by swapping the V and W inputs
  wire [2:0] hall_nxt = polarity_r[msc_pkg::POL_HALL_BIT] ? {hall_each[1], hall_each[2], hall_each[0]}
                        : hall_each;
  wire [31:0] enc_nxt = polarity_r[msc_pkg::POL_ENC_BIT] ? (32'h0000_0000 - enc_count_in)
                        : enc_count_in;
  // Angle input is taken as 0..3599 tenths of a degree
  wire [15:0] ang_pol = !polarity_r[msc_pkg::POL_ANGLE_BIT] ? angle_in :
                        (angle_in == 16'h0000) ? 16'h0000 : (msc_pkg::ANGLE_FULL - angle_in);
  wire signed [16:0] full17 = $signed({1'b0, msc_pkg::ANGLE_FULL});
  wire signed [16:0] ang_sum = $signed({1'b0, ang_pol}) + $signed({angle_ofs_r[15], angle_ofs_r});
  wire signed [16:0] ang_wrap = (ang_sum < 17'sh00000) ? (ang_sum + full17) :
                                (ang_sum >= full17) ? (ang_sum - full17) : ang_sum;

  logic [2:0] motor_nxt;
  always_comb begin
    // motor_nxt bit 0 is U, bit 1 V, bit 2 W; pwm_in bit 0 is PWM 1
    unique case (msc_pkg::msc_phase_t'(phase_r[2:0]))
      msc_pkg::PH_UVW: motor_nxt = {pwm_in[2], pwm_in[1], pwm_in[0]};
      msc_pkg::PH_UWV: motor_nxt = {pwm_in[1], pwm_in[2], pwm_in[0]};
      msc_pkg::PH_VUW: motor_nxt = {pwm_in[2], pwm_in[0], pwm_in[1]};
      msc_pkg::PH_VWU: motor_nxt = {pwm_in[1], pwm_in[0], pwm_in[2]};
      msc_pkg::PH_WUV: motor_nxt = {pwm_in[0], pwm_in[2], pwm_in[1]};
      msc_pkg::PH_WVU: motor_nxt = {pwm_in[0], pwm_in[1], pwm_in[2]};
      default: motor_nxt = 3'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hall_r <= 3'h0;
      enc_r <= 32'h0000_0000;
      angle_r <= 16'h0000;
      motor_r <= 3'h0;
      hall_valid_r <= 1'b0;
    end else begin
      hall_r <= hall_nxt;
      hall_valid_r <= (hall_nxt >= msc_pkg::HALL_MIN) && (hall_nxt <= msc_pkg::HALL_MAX);
      enc_r <= enc_nxt;
      angle_r <= ang_wrap[15:0];
      motor_r <= motor_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign od_ack = ack_r;
  assign od_abort = abort_r;
  assign od_rdata = rdata_r;
  assign enc_count_out = enc_r;
  assign hall_out = hall_r;
  assign hall_valid = hall_valid_r;
  assign angle_out = angle_r;
  assign motor_uvw = motor_r;
  assign pole_pairs = pole_pairs_r;
  assign d_pgain = d_pgain_r;
  assign q_pgain = q_pgain_r;
  assign q_igain = q_igain_r;
  assign cur_bw = cur_bw_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_bad_bw_write;
    wr && hit_bw && !ok_bw;
  endsequence

  property p_bw_refused;
    @(posedge clk_sys) disable iff (!resetn) s_bad_bw_write |=> $stable(cur_bw_r) ##0 od_abort;
  endproperty
  a_bw_refused: assert property (p_bw_refused) else $error("bad bandwidth write not refused");

  property p_bw_range;
    @(posedge clk_sys) disable iff (!resetn) (cur_bw_r >= msc_pkg::CUR_BW_MIN) && (cur_bw_r <= msc_pkg::CUR_BW_MAX);
  endproperty
  a_bw_range: assert property (p_bw_range) else $error("bandwidth out of range");

  property p_ro_refused;
    @(posedge clk_sys) disable iff (!resetn) (wr && (hit_fent || hit_hall || hit_gn)) |=> od_abort && od_ack;
  endproperty
  a_ro_refused: assert property (p_ro_refused) else $error("read-only write not aborted");

  property p_gain_range;
    @(posedge clk_sys) disable iff (!resetn)
      (d_pgain_r <= msc_pkg::GAIN_MAX) && (q_pgain_r <= msc_pkg::GAIN_MAX) && (q_igain_r <= msc_pkg::GAIN_MAX);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out of range");

  property p_qi_write;
    @(posedge clk_sys) disable iff (!resetn) (wr && ok_qi) |=> (q_igain_r == $past(od_wdata)) && !od_abort;
  endproperty
  a_qi_write: assert property (p_qi_write) else $error("integral gain write lost");

  property p_pol_reserved;
    @(posedge clk_sys) disable iff (!resetn) polarity_r[7:4] == 4'h0;
  endproperty
  a_pol_reserved: assert property (p_pol_reserved) else $error("reserved polarity bits set");

  property p_enc_invert;
    @(posedge clk_sys) disable iff (!resetn)
      $past(polarity_r[0]) |-> (enc_count_out + $past(enc_count_in) == 32'h0000_0000);
  endproperty
  a_enc_invert: assert property (p_enc_invert) else $error("encoder count not inverted");

  property p_angle_wrap;
    @(posedge clk_sys) disable iff (!resetn) ($past(angle_in) < 16'h0e10) |-> (angle_out < 16'h0e10);
  endproperty
  a_angle_wrap: assert property (p_angle_wrap) else $error("angle outside one turn");

  property p_phase_uvw;
    @(posedge clk_sys) disable iff (!resetn) ($past(phase_r) == 16'h0000) |-> (motor_uvw == $past(pwm_in));
  endproperty
  a_phase_uvw: assert property (p_phase_uvw) else $error("direct phase order broken");

  property p_phase_range;
    @(posedge clk_sys) disable iff (!resetn) phase_r <= msc_pkg::PHASE_MAX;
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("phase order code illegal");

  property p_count_read;
    @(posedge clk_sys) disable iff (!resetn) (od_req && !od_wr && hit_cnt) |=> od_rdata == {28'h0, $past(log_count)};
  endproperty
  a_count_read: assert property (p_count_read) else $error("fault count read wrong");

endmodule
`default_nettype wire

// ==== msc_pkg.sv ====
// Constants shared by the motor sensor and current parameter bank
`default_nettype none
package msc_pkg;

  // ----------------------------------------------------------------
  // Object indices and subindices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_POLARITY = 16'h4009;
  localparam logic [15:0] IDX_POLE_PAIRS = 16'h400a;
  localparam logic [15:0] IDX_FAULT_LOG = 16'h4080;
  localparam logic [15:0] IDX_PHASE_ORDER = 16'h4100;
  localparam logic [15:0] IDX_ANGLE_OFS = 16'h4101;
  localparam logic [15:0] IDX_HALL_PAT = 16'h4107;
  localparam logic [15:0] IDX_CUR_GAINS = 16'h4205;
  localparam logic [15:0] IDX_CUR_BW = 16'h4206;

  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_D_PGAIN = 8'h01;
  localparam logic [7:0] SUB_Q_PGAIN = 8'h04;
  localparam logic [7:0] SUB_Q_IGAIN = 8'h05;
  localparam logic [7:0] SUB_FAULT_FIRST = 8'h01;
  localparam logic [7:0] SUB_FAULT_LAST = 8'h0a;
  localparam logic [7:0] CUR_GAIN_ENTRIES = 8'h06;

  // ----------------------------------------------------------------
  // Polarity field positions
  // ----------------------------------------------------------------
  localparam int POL_ENC_BIT = 0;
  localparam int POL_HALL_BIT = 1;
  localparam int POL_HALL_EACH_BIT = 2;
  localparam int POL_ANGLE_BIT = 3;
  localparam logic [7:0] POL_USED_MASK = 8'h0f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] POLARITY_RST = 8'h00;
  localparam logic [7:0] POLE_PAIRS_RST = 8'h00;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [15:0] ANGLE_OFS_RST = 16'h0000;
  localparam logic [31:0] GAIN_RST = 32'h0000_03e8;
  localparam logic [15:0] CUR_BW_RST = 16'h07d0;

  // ----------------------------------------------------------------
  // Value ranges
  // ----------------------------------------------------------------
  localparam logic [31:0] GAIN_MAX = 32'h05f5_e100;
  localparam logic [15:0] CUR_BW_MIN = 16'h03e8;
  localparam logic [15:0] CUR_BW_MAX = 16'h2710;
  localparam logic signed [15:0] ANGLE_OFS_MIN = 16'shf1f0;
  localparam logic signed [15:0] ANGLE_OFS_MAX = 16'sh0e10;
  localparam logic [15:0] ANGLE_FULL = 16'h0e10;
  localparam logic [15:0] PHASE_MAX = 16'h0005;
  localparam logic [2:0] HALL_MIN = 3'h1;
  localparam logic [2:0] HALL_MAX = 3'h6;
  localparam logic [3:0] FAULT_DEPTH = 4'ha;

  // Phase order codes: PWM 1,2,3 onto the listed motor phases
  typedef enum logic [2:0] {
    PH_UVW = 3'h0,
    PH_UWV = 3'h1,
    PH_VUW = 3'h2,
    PH_VWU = 3'h3,
    PH_WUV = 3'h4,
    PH_WVU = 3'h5
  } msc_phase_t;

endpackage
`default_nettype wire

// ==== msc_fault_log.sv ====
// Ten-entry fault code history with append, overflow shift and clear
`timescale 1ns/1ps
`default_nettype none

module msc_fault_log (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic push,
  input wire logic [15:0] code,
  input wire logic clear,
  input wire logic [3:0] rd_sel,
  output logic [15:0] rd_data,
  output logic [3:0] count
);

  logic [15:0] entry_r [0:9];
  logic [3:0] count_r;
  logic full;

  assign full = (count_r == msc_pkg::FAULT_DEPTH);
  assign count = count_r;
  // Selector counts from one; zero and values above ten read as zero
  assign rd_data = (rd_sel >= 4'h1 && rd_sel <= msc_pkg::FAULT_DEPTH) ? entry_r[rd_sel - 4'h1] : 16'h0000;

  // A fault in the clear cycle survives as the sole entry
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_r <= 4'h0;
      for (int i = 0; i < 10; i++) entry_r[i] <= 16'h0000;
    end else if (clear) begin
      for (int i = 1; i < 10; i++) entry_r[i] <= 16'h0000;
      entry_r[0] <= push ? code : 16'h0000;
      count_r <= push ? 4'h1 : 4'h0;
    end else if (push && !full) begin
      entry_r[count_r] <= code;
      count_r <= count_r + 4'h1;
    end else if (push) begin
      // Full: oldest is dropped so the newest code is never lost
      for (int i = 0; i < 9; i++) entry_r[i] <= entry_r[i + 1];
      entry_r[9] <= code;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_count_bounded;
    @(posedge clk_sys) disable iff (!resetn) count_r <= msc_pkg::FAULT_DEPTH;
  endproperty
  a_count_bounded: assert property (p_count_bounded) else $error("fault count above ten");

  sequence s_plain_clear;
    clear && !push;
  endsequence

  property p_clear_empties;
    @(posedge clk_sys) disable iff (!resetn) s_plain_clear |=> (count_r == 4'h0) && (entry_r[0] == 16'h0000);
  endproperty
  a_clear_empties: assert property (p_clear_empties) else $error("clear left entries");

  property p_append;
    @(posedge clk_sys) disable iff (!resetn)
      (push && !clear && !full) |=> (count_r == $past(count_r) + 4'h1) && (entry_r[$past(count_r)] == $past(code));
  endproperty
  a_append: assert property (p_append) else $error("fault code not appended");

endmodule
`default_nettype wire

// ==== msc_master.sv ====
// Fieldbus master model that issues object dictionary accesses
`timescale 1ns/1ps
`default_nettype none

module msc_master (
  input wire logic clk_sys,
  output logic od_req,
  output logic od_wr,
  output logic [15:0] od_index,
  output logic [7:0] od_sub,
  output logic [31:0] od_wdata,
  input wire logic od_ack,
  input wire logic od_abort,
  input wire logic [31:0] od_rdata
);
  initial begin
    od_req = 1'b0;
    od_wr = 1'b0;
    od_index = 16'h0000;
    od_sub = 8'h00;
    od_wdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // One access, held until the edge that takes it
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wdata, output logic ack, output logic abort,
                        output logic [31:0] rdata);
    @(posedge clk_sys);
    #1;
    od_req = 1'b1;
    od_wr = wr;
    od_index = idx;
    od_sub = sub;
    od_wdata = wdata;
    @(posedge clk_sys);
    #1;
    ack = od_ack;
    abort = od_abort;
    rdata = od_rdata;
    od_req = 1'b0;
    // Stale data must not look valid once the request is gone
    od_wdata = ~wdata;
  endtask
endmodule

`default_nettype wire

// ==== msc_param_bank_test.sv ====
// Self-checking bench for the motor sensor and current parameter bank
`timescale 1ns/1ps
`default_nettype none

module msc_param_bank_test;
  logic clk_sys, resetn, od_req, od_wr, od_ack, od_abort, fault_push, hall_valid;
  logic [15:0] od_index, fault_code, angle_in, angle_out, cur_bw;
  logic [7:0] od_sub, pole_pairs;
  logic [31:0] od_wdata, od_rdata, enc_count_in, enc_count_out, d_pgain, q_pgain, q_igain;
  logic [2:0] hall_in, hall_out, pwm_in, motor_uvw;
  int num_errors = 0;
  int checked = 0;
  // Motor bits expected for PWM1 alone and PWM2 alone, per phase code
  logic [2:0] exp_a [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  logic [2:0] exp_b [6] = '{3'h2, 3'h4, 3'h1, 3'h4, 3'h1, 3'h2};

  msc_param_bank u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .od_req(od_req), .od_wr(od_wr), .od_index(od_index),
    .od_sub(od_sub), .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
    .fault_push(fault_push), .fault_code(fault_code), .enc_count_in(enc_count_in),
    .enc_count_out(enc_count_out), .hall_in(hall_in), .hall_out(hall_out), .hall_valid(hall_valid),
    .angle_in(angle_in), .angle_out(angle_out), .pwm_in(pwm_in), .motor_uvw(motor_uvw),
    .pole_pairs(pole_pairs), .d_pgain(d_pgain), .q_pgain(q_pgain), .q_igain(q_igain), .cur_bw(cur_bw)
  );

  msc_master u_master (
    .clk_sys(clk_sys), .od_req(od_req), .od_wr(od_wr), .od_index(od_index), .od_sub(od_sub),
    .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("Mismatches %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask

  task automatic cyc;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic x(input logic wr, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                   input logic ab, input logic [31:0] e);
    logic a, b;
    logic [31:0] q;
    u_master.access(wr, i, s, d, a, b, q);
    chk("od_ack", 32'(a), 32'h1);
    chk("od_abort", 32'(b), 32'(ab));
    chk("od_rdata", q, e);
  endtask

  task automatic w(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic ab);
    x(1'b1, i, s, d, ab, 32'h0);
  endtask

  task automatic r(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    x(1'b0, i, s, 32'h0, 1'b0, e);
  endtask

  // Codes are pushed on consecutive edges to stress the append path
  task automatic push(input logic [15:0] c0, input int n);
    fault_push = 1'b1;
    for (int i = 0; i < n; i++) begin
      fault_code = c0 + 16'(i);
      cyc();
    end
    fault_push = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  initial begin
    resetn = 1'b0;
    fault_push = 1'b0;
    fault_code = 16'h0000;
    enc_count_in = 32'h0000_0005;
    hall_in = 3'h2;
    angle_in = 16'h0dde;
    pwm_in = 3'h0;
    repeat (6) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    r(16'h4009, 8'h0, 32'h0);
    r(16'h400a, 8'h0, 32'h0);
    r(16'h4080, 8'h0, 32'h0);
    r(16'h4080, 8'h1, 32'h0);
    r(16'h4100, 8'h0, 32'h0);
    r(16'h4101, 8'h0, 32'h0);
    r(16'h4205, 8'h1, 32'h3e8);
    r(16'h4205, 8'h4, 32'h3e8);
    r(16'h4205, 8'h5, 32'h3e8);
    r(16'h4206, 8'h0, 32'h7d0);
    x(1'b0, 16'h4207, 8'h0, 32'h0, 1'b1, 32'h0);
    w(16'h4205, 8'h2, 32'h1, 1'b1);
    w(16'h4205, 8'h0, 32'h6, 1'b1);
    r(16'h4205, 8'h0, 32'h6);
    w(16'h4107, 8'h0, 32'h1, 1'b1);
    w(16'h4205, 8'h1, 32'h05f5e100, 1'b0);
    chk("d_pgain", d_pgain, 32'h05f5e100);
    w(16'h4205, 8'h4, 32'h05f5e101, 1'b1);
    w(16'h4205, 8'h5, 32'h0, 1'b0);
    chk("q_pgain", q_pgain, 32'h3e8);
    chk("q_igain", q_igain, 32'h0);
    w(16'h4206, 8'h0, 32'h3e7, 1'b1);
    w(16'h4206, 8'h0, 32'h2710, 1'b0);
    w(16'h4206, 8'h0, 32'h2711, 1'b1);
    chk("cur_bw", 32'(cur_bw), 32'h2710);
    w(16'h400a, 8'h0, 32'hff, 1'b0);
    w(16'h400a, 8'h0, 32'h100, 1'b1);
    chk("pole_pairs", 32'(pole_pairs), 32'hff);
    w(16'h4101, 8'h0, 32'hf1ef, 1'b1);
    w(16'h4101, 8'h0, 32'h0e11, 1'b1);
    w(16'h4101, 8'h0, 32'hf1f0, 1'b0);
    cyc();
    chk("angle_out", 32'(angle_out), 32'h0dde);
    w(16'h4101, 8'h0, 32'h64, 1'b0);
    r(16'h4101, 8'h0, 32'h64);
    chk("angle_out", 32'(angle_out), 32'h32);
    chk("enc_count_out", enc_count_out, 32'h5);
    chk("hall_out", 32'(hall_out), 32'h2);
    chk("hall_valid", 32'(hall_valid), 32'h1);
    w(16'h4009, 8'h0, 32'h1, 1'b0);
    cyc();
    chk("enc_count_out", enc_count_out, 32'hffff_fffb);
    w(16'h4009, 8'h0, 32'h2, 1'b0);
    cyc();
    chk("hall_out", 32'(hall_out), 32'h4);
    w(16'h4009, 8'h0, 32'h4, 1'b0);
    cyc();
    chk("hall_out", 32'(hall_out), 32'h5);
    w(16'h4009, 8'h0, 32'h8, 1'b0);
    cyc();
    chk("angle_out", 32'(angle_out), 32'h96);
    w(16'h4009, 8'h0, 32'hff, 1'b0);
    r(16'h4009, 8'h0, 32'hf);
    w(16'h4009, 8'h0, 32'h0, 1'b0);
    hall_in = 3'h7;
    cyc();
    chk("hall_valid", 32'(hall_valid), 32'h0);
    r(16'h4107, 8'h0, 32'h7);
    for (int k = 0; k < 6; k++) begin
      w(16'h4100, 8'h0, 32'(k), 1'b0);
      pwm_in = 3'h1;
      cyc();
      chk("motor_uvw", 32'(motor_uvw), 32'(exp_a[k]));
      pwm_in = 3'h2;
      cyc();
      chk("motor_uvw", 32'(motor_uvw), 32'(exp_b[k]));
    end
    w(16'h4100, 8'h0, 32'h6, 1'b1);
    cyc();
    chk("motor_uvw", 32'(motor_uvw), 32'h2);
    push(16'h1001, 3);
    r(16'h4080, 8'h0, 32'h3);
    r(16'h4080, 8'h1, 32'h1001);
    r(16'h4080, 8'h3, 32'h1003);
    r(16'h4080, 8'h4, 32'h0);
    push(16'h1004, 8);
    r(16'h4080, 8'h0, 32'ha);
    r(16'h4080, 8'h1, 32'h1002);
    r(16'h4080, 8'ha, 32'h100b);
    w(16'h4080, 8'h1, 32'h1, 1'b1);
    w(16'h4080, 8'h0, 32'h5, 1'b1);
    r(16'h4080, 8'h0, 32'ha);
    w(16'h4080, 8'h0, 32'h0, 1'b0);
    r(16'h4080, 8'h0, 32'h0);
    r(16'h4080, 8'ha, 32'h0);
    resetn = 1'b0;
    cyc();
    resetn = 1'b1;
    chk("d_pgain", d_pgain, 32'h3e8);
    chk("pole_pairs", 32'(pole_pairs), 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
